// >>> include/acf_defs.svh
`ifndef ACF_DEFS_SVH
`define ACF_DEFS_SVH

`define ACF_NCH 8
`define ACF_WORD_W 24
`define ACF_DATA_W 16
`define ACF_ADDR_W 6
`define ACF_SEL_OFF_HI 3'h0
`define ACF_SEL_OFF_MID 3'h1
`define ACF_SEL_OFF_LO 3'h2
`define ACF_SEL_GAIN_HI 3'h3
`define ACF_SEL_GAIN_MID 3'h4
`define ACF_SEL_GAIN_LO 3'h5
`define ACF_SEL_SYNC 3'h6
`define ACF_OFF_RESET 24'h00_0000
`define ACF_GAIN_NOMINAL 24'h55_5555
`define ACF_SYNC_RESET 8'h00
`define ACF_GAIN_SHIFT 30
`define ACF_RES_MAX 20'h0_7FFF
`define ACF_RES_MIN 20'hF_8000
`define ACF_CLK_PERIOD_NS 10
`define ACF_BITCLK_PERIOD_NS 160
`define ACF_BIT_HALF (`ACF_BITCLK_PERIOD_NS / `ACF_CLK_PERIOD_NS / 2)
`define ACF_MOD_DIV 4
`define ACF_DEC_64 3'h1
`define ACF_DEC_128 3'h2
`define ACF_DEC_256 3'h3
`define ACF_DEC_512 3'h4
`define ACF_LAYOUT_WAIT 2'h2
`define ACF_CAL_LAST 4'h9
`define ACF_SCAN_LAST 4'h8

`endif

// >>> include/acf_pkg.sv
package acf_pkg;

    typedef logic [7:0] acf_byte_t;
    typedef logic [23:0] acf_word_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SCAN = 5'h02,
        ST_HOLD = 5'h04,
        ST_CAL = 5'h08,
        ST_SEND = 5'h10
    } acf_state_t;

    typedef enum logic [2:0] {
        LY_EIGHT = 3'h1,
        LY_TWO = 3'h2,
        LY_ONE = 3'h4
    } acf_layout_t;

endpackage : acf_pkg

// >>> logic/acf_coef_mem.sv
`timescale 1ns/1ps
`include "acf_defs.svh"

module acf_coef_mem #(
    parameter logic [23:0] FACTORY_GAIN = `ACF_GAIN_NOMINAL
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register side
    input wire logic wrEn,
    input wire logic [`ACF_ADDR_W-1:0] wrAddr,
    input wire acf_pkg::acf_byte_t wrData,
    input wire logic [`ACF_ADDR_W-1:0] rdAddr,
    output acf_pkg::acf_byte_t rdData,
    // Channel side
    input wire logic [2:0] chanSel,
    output acf_pkg::acf_word_t chanOffset,
    output acf_pkg::acf_word_t chanGain,
    output acf_pkg::acf_byte_t chanSync
);
    import acf_pkg::*;

    acf_word_t offQ [`ACF_NCH];
    acf_word_t offD [`ACF_NCH];
    acf_word_t gainQ [`ACF_NCH];
    acf_word_t gainD [`ACF_NCH];
    acf_byte_t syncQ [`ACF_NCH];
    acf_byte_t syncD [`ACF_NCH];
    acf_byte_t rdD;

    function automatic acf_byte_t pickByte(input acf_word_t w, input logic [1:0] idx);
        pickByte = (idx == 2'h0) ? w[23:16] : (idx == 2'h1) ? w[15:8] : w[7:0];
    endfunction : pickByte

    function automatic acf_word_t putByte(input acf_word_t w, input logic [1:0] idx,
                                          input acf_byte_t b);
        putByte = w;
        if (idx == 2'h0) putByte[23:16] = b;
        else if (idx == 2'h1) putByte[15:8] = b;
        else putByte[7:0] = b;
    endfunction : putByte

    always_comb begin
        logic [2:0] ch;
        logic [2:0] sel;
        ch = wrAddr[5:3];
        sel = wrAddr[2:0];
        offD = offQ;
        gainD = gainQ;
        syncD = syncQ;
        if (wrEn) begin
            if (sel <= `ACF_SEL_OFF_LO) begin
                offD[ch] = putByte(offQ[ch], sel[1:0], wrData);
            end else if (sel <= `ACF_SEL_GAIN_LO) begin
                gainD[ch] = putByte(gainQ[ch], 2'(sel - `ACF_SEL_GAIN_HI), wrData);
            end else if (sel == `ACF_SEL_SYNC) begin
                syncD[ch] = wrData;
            end
        end
    end

    always_comb begin
        logic [2:0] ch;
        logic [2:0] sel;
        ch = rdAddr[5:3];
        sel = rdAddr[2:0];
        rdD = 8'h00;
        if (sel <= `ACF_SEL_OFF_LO) rdD = pickByte(offQ[ch], sel[1:0]);
        else if (sel <= `ACF_SEL_GAIN_LO) rdD = pickByte(gainQ[ch], 2'(sel - `ACF_SEL_GAIN_HI));
        else if (sel == `ACF_SEL_SYNC) rdD = syncQ[ch];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < `ACF_NCH; i++) begin
                offQ[i] <= `ACF_OFF_RESET;
                gainQ[i] <= FACTORY_GAIN;
                syncQ[i] <= `ACF_SYNC_RESET;
            end
            rdData <= 8'h00;
            chanOffset <= `ACF_OFF_RESET;
            chanGain <= FACTORY_GAIN;
            chanSync <= `ACF_SYNC_RESET;
        end else begin
            offQ <= offD;
            gainQ <= gainD;
            syncQ <= syncD;
            rdData <= rdD;
            chanOffset <= offQ[chanSel];
            chanGain <= gainQ[chanSel];
            chanSync <= syncQ[chanSel];
        end
    end

endmodule : acf_coef_mem

// >>> logic/acf_corrector.sv
`timescale 1ns/1ps
`include "acf_defs.svh"

module acf_corrector (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Operands
    input wire logic inValid,
    input wire acf_pkg::acf_word_t rawIn,
    input wire acf_pkg::acf_word_t offsetIn,
    input wire acf_pkg::acf_word_t gainIn,
    // Result
    output logic outValid,
    output logic [`ACF_DATA_W-1:0] result,
    output logic saturated
);
    import acf_pkg::*;

    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [19:0] scaled;
    logic [`ACF_DATA_W-1:0] resD;
    logic satD;

    always_comb begin
        // Offset is removed before the gain multiply
        diff = $signed({rawIn[23], rawIn}) - $signed({offsetIn[23], offsetIn});
        prod = diff * $signed({1'b0, gainIn});
        // Gain/1024 * 4194300/2^42 taken as gain/2^30; nominal gain gives 1/192
        scaled = prod[`ACF_GAIN_SHIFT +: 20];
        satD = 1'b0;
        resD = scaled[15:0];
        if (scaled > $signed(`ACF_RES_MAX)) begin
            resD = 16'h7FFF;
            satD = 1'b1;
        end else if (scaled < $signed(`ACF_RES_MIN)) begin
            resD = 16'h8000;
            satD = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outValid <= 1'b0;
            result <= 16'h0000;
            saturated <= 1'b0;
        end else begin
            outValid <= inValid;
            result <= resD;
            saturated <= satD;
        end
    end

endmodule : acf_corrector

// >>> logic/acf_cal_format.sv
// Summary of operation
// - Corrections only under serial register control.
// - Offset is signed 24-bit across three bytes.
// - Nominal gain: offset unit is -1/192 LSB.
// - Offset subtracted before gain multiply.
// - Reset clears offset values to zero.
// - Factory gain in three bytes, writable.
// - Reset reloads factory gain, discarding writes.
// - Output follows offset-gain formula approximately.
// - Shared sync; per-channel delay register.
// - Zero delay: all channels respond together.
// - Delay at most one conversion, rate-dependent step.
// - Step and bits follow decimation rate.
// - Delays shift first strobe and settling.
// - All sinc5, one zero delay: no shift.
// - All sinc5, all delayed: shift by minimum.
// - Sinc5 later channels settle one frame later.
// - All wideband: wait for most delayed channel.
// - Layout pins sampled once after reset.
// - Pins 00: one channel per line.
// - Pins 01: ch0-3 line 0, ch4-7 line 1.
// - Upper pin high: all channels on line 0.
// - Word is 8-bit header, 16-bit result, MSB first.
// - Strobe low one bit before first header bit.
`timescale 1ns/1ps
`include "acf_defs.svh"

module acf_cal_format #(
    parameter logic [23:0] FACTORY_GAIN = `ACF_GAIN_NOMINAL,
    parameter int MOD_DIV = `ACF_MOD_DIV,
    parameter int BIT_HALF = `ACF_BIT_HALF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode inputs from the control logic
    input wire logic serialCtrl,
    input wire logic [7:0] chanSinc5,
    input wire logic [2:0] decCode,
    // Register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [`ACF_ADDR_W-1:0] regAddr,
    input wire acf_pkg::acf_byte_t regWrData,
    output acf_pkg::acf_byte_t regRdData,
    output logic regRdValid,
    // Raw conversions from the filters
    input wire logic rawValid,
    input wire logic [`ACF_NCH*`ACF_WORD_W-1:0] rawData,
    // Pins
    input wire logic syncIn_n,
    input wire logic line_layout_pin_hi,
    input wire logic line_layout_pin_lo,
    output logic bit_clock_out,
    output logic frame_strobe_n,
    output logic [`ACF_NCH-1:0] serial_out_line
);
    import acf_pkg::*;

    // Pin synchronisers
    logic syncMeta_q, syncSync_q, syncPrev_q;
    logic [1:0] layMeta_q, laySync_q;
    logic [1:0] layWait_q, layWait_d;
    logic layTaken_q, layTaken_d;
    acf_layout_t layout_q, layout_d;
    logic syncEdge;

    always_ff @(posedge clk) begin
        syncMeta_q <= syncIn_n;
        syncSync_q <= syncMeta_q;
        layMeta_q <= {line_layout_pin_hi, line_layout_pin_lo};
        laySync_q <= layMeta_q;
    end

    // Layout is caught once; later pin changes are ignored
    always_comb begin
        layWait_d = layWait_q;
        layTaken_d = layTaken_q;
        layout_d = layout_q;
        if (!layTaken_q) begin
            layWait_d = 2'(layWait_q + 2'h1);
            if (layWait_q == `ACF_LAYOUT_WAIT) begin
                layTaken_d = 1'b1;
                if (laySync_q[1]) layout_d = LY_ONE;
                else if (laySync_q[0]) layout_d = LY_TWO;
                else layout_d = LY_EIGHT;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncPrev_q <= 1'b1;
            layWait_q <= 2'h0;
            layTaken_q <= 1'b0;
            layout_q <= LY_EIGHT;
        end else begin
            syncPrev_q <= syncSync_q;
            layWait_q <= layWait_d;
            layTaken_q <= layTaken_d;
            layout_q <= layout_d;
        end
    end

    assign syncEdge = syncSync_q & ~syncPrev_q;

    // Free-running bit clock divider
    logic [7:0] divCnt_q, divCnt_d;
    logic bitClk_d;
    logic riseTick;

    always_comb begin
        riseTick = (divCnt_q == 8'(BIT_HALF - 1)) && !bit_clock_out;
        divCnt_d = 8'(divCnt_q + 8'h01);
        bitClk_d = bit_clock_out;
        if (divCnt_q == 8'(BIT_HALF - 1)) begin
            divCnt_d = 8'h00;
            bitClk_d = ~bit_clock_out;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divCnt_q <= 8'h00;
            bit_clock_out <= 1'b0;
        end else begin
            divCnt_q <= divCnt_d;
            bit_clock_out <= bitClk_d;
        end
    end

    // Coefficient store and correction datapath
    logic [3:0] step_q, step_d;
    acf_word_t memOffset, memGain, offsetUse, gainUse;
    acf_byte_t memSync;
    logic corrValid, corrInValid, corrSat;
    logic [`ACF_DATA_W-1:0] corrRes;
    logic [2:0] inCh, outCh;
    acf_state_t state_q, state_d;
    acf_word_t rawQ [`ACF_NCH], rawD [`ACF_NCH];

    acf_coef_mem #(
        .FACTORY_GAIN(FACTORY_GAIN)
    ) uMem (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(regWrEn & serialCtrl),
        .wrAddr(regAddr),
        .wrData(regWrData),
        .rdAddr(regAddr),
        .rdData(regRdData),
        .chanSel(step_q[2:0]),
        .chanOffset(memOffset),
        .chanGain(memGain),
        .chanSync(memSync)
    );

    always_comb begin
        inCh = 3'(step_q - 4'h1);
        outCh = 3'(step_q - 4'h2);
        corrInValid = (state_q == ST_CAL) && (step_q >= 4'h1) && (step_q <= 4'h8);
        offsetUse = serialCtrl ? memOffset : `ACF_OFF_RESET;
        gainUse = serialCtrl ? memGain : `ACF_GAIN_NOMINAL;
    end

    acf_corrector uCorr (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(corrInValid),
        .rawIn(rawQ[inCh]),
        .offsetIn(offsetUse),
        .gainIn(gainUse),
        .outValid(corrValid),
        .result(corrRes),
        .saturated(corrSat)
    );

    // Delay in modulator clocks for the active decimation rate
    function automatic logic [9:0] phaseMods(input acf_byte_t r, input logic [2:0] dec);
        unique case (dec)
            3'h0: phaseMods = {5'h00, r[7:3]};
            `ACF_DEC_64: phaseMods = {4'h0, r[7:2]};
            `ACF_DEC_128: phaseMods = {3'h0, r[7:1]};
            `ACF_DEC_256: phaseMods = {2'h0, r};
            `ACF_DEC_512: phaseMods = {1'b0, r, 1'b0};
            default: phaseMods = {r, 2'h0};
        endcase
    endfunction : phaseMods

    // Frame sequencer
    acf_word_t wordQ [`ACF_NCH], wordD [`ACF_NCH];
    logic [9:0] dlyQ [`ACF_NCH], dlyD [`ACF_NCH];
    logic [9:0] minDly_q, minDly_d, maxDly_q, maxDly_d;
    logic [19:0] hold_q, hold_d;
    logic [7:0] late_q, late_d, unsettled_q, unsettled_d;
    logic [2:0] sendWord_q, sendWord_d;
    logic [4:0] sendBit_q, sendBit_d;
    logic sendLead_q, sendLead_d, sendDone_q, sendDone_d;
    logic strobeN_d;
    logic [`ACF_NCH-1:0] lineD;
    logic rdValid_d;

    always_comb begin
        logic [9:0] d;
        logic [3:0] perLine;
        logic [3:0] lanes;
        logic [2:0] ch;
        d = 10'h000;
        perLine = (layout_q == LY_ONE) ? 4'h8 : (layout_q == LY_TWO) ? 4'h4 : 4'h1;
        lanes = 4'(4'h8 / perLine);
        ch = 3'h0;
        state_d = state_q;
        step_d = step_q;
        rawD = rawQ;
        wordD = wordQ;
        dlyD = dlyQ;
        minDly_d = minDly_q;
        maxDly_d = maxDly_q;
        hold_d = hold_q;
        late_d = late_q;
        unsettled_d = unsettled_q;
        sendWord_d = sendWord_q;
        sendBit_d = sendBit_q;
        sendLead_d = sendLead_q;
        sendDone_d = sendDone_q;
        strobeN_d = frame_strobe_n;
        lineD = serial_out_line;
        rdValid_d = regRdEn;
        if (syncEdge) begin
            // A sync edge abandons any frame in flight
            state_d = ST_SCAN;
            step_d = 4'h0;
            minDly_d = 10'h3FF;
            maxDly_d = 10'h000;
            unsettled_d = 8'hFF;
            strobeN_d = 1'b1;
            lineD = '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (rawValid) begin
                        for (int i = 0; i < `ACF_NCH; i++) begin
                            rawD[i] = rawData[i*`ACF_WORD_W +: `ACF_WORD_W];
                        end
                        state_d = ST_CAL;
                        step_d = 4'h0;
                    end
                end
                ST_SCAN: begin
                    step_d = 4'(step_q + 4'h1);
                    if (step_q >= 4'h1) begin
                        d = serialCtrl ? phaseMods(memSync, decCode) : 10'h000;
                        dlyD[inCh] = d;
                        if (d < minDly_q) minDly_d = d;
                        if (d > maxDly_q) maxDly_d = d;
                    end
                    if (step_q == `ACF_SCAN_LAST) begin
                        state_d = ST_HOLD;
                        // Mixed filters wait for the latest channel as well
                        if (&chanSinc5) begin
                            hold_d = 20'(minDly_d * MOD_DIV);
                            for (int i = 0; i < `ACF_NCH; i++) begin
                                late_d[i] = dlyD[i] != minDly_d;
                            end
                        end else begin
                            hold_d = 20'(maxDly_d * MOD_DIV);
                            late_d = 8'h00;
                        end
                    end
                end
                ST_HOLD: begin
                    // Frames are withheld until the chosen channel is aligned
                    hold_d = 20'(hold_q - 20'h1);
                    if (hold_q == 20'h0) begin
                        hold_d = 20'h0;
                        state_d = ST_IDLE;
                    end
                end
                ST_CAL: begin
                    step_d = 4'(step_q + 4'h1);
                    if (corrValid) begin
                        wordD[outCh] = {1'b0, unsettled_q[outCh], 1'b0, chanSinc5[outCh],
                                        corrSat, outCh, corrRes};
                    end
                    if (step_q == `ACF_CAL_LAST) begin
                        unsettled_d = unsettled_q & late_q;
                        late_d = 8'h00;
                        state_d = ST_SEND;
                        sendLead_d = 1'b1;
                        sendDone_d = 1'b0;
                        sendWord_d = 3'h0;
                        sendBit_d = 5'd23;
                    end
                end
                ST_SEND: begin
                    if (riseTick) begin
                        if (sendLead_q) begin
                            strobeN_d = 1'b0;
                            sendLead_d = 1'b0;
                        end else if (sendDone_q) begin
                            lineD = '0;
                            state_d = ST_IDLE;
                        end else begin
                            strobeN_d = 1'b1;
                            for (int l = 0; l < `ACF_NCH; l++) begin
                                ch = 3'(l * perLine + sendWord_q);
                                lineD[l] = (4'(l) < lanes) ? wordQ[ch][sendBit_q] : 1'b0;
                            end
                            if (sendBit_q == 5'd0) begin
                                sendBit_d = 5'd23;
                                sendWord_d = 3'(sendWord_q + 3'h1);
                                if (4'(sendWord_q) == 4'(perLine - 4'h1)) sendDone_d = 1'b1;
                            end else begin
                                sendBit_d = 5'(sendBit_q - 5'd1);
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            step_q <= 4'h0;
            for (int i = 0; i < `ACF_NCH; i++) begin
                rawQ[i] <= 24'h00_0000;
                wordQ[i] <= 24'h00_0000;
                dlyQ[i] <= 10'h000;
            end
            minDly_q <= 10'h000;
            maxDly_q <= 10'h000;
            hold_q <= 20'h0_0000;
            late_q <= 8'h00;
            unsettled_q <= 8'hFF;
            sendWord_q <= 3'h0;
            sendBit_q <= 5'd23;
            sendLead_q <= 1'b0;
            sendDone_q <= 1'b0;
            frame_strobe_n <= 1'b1;
            serial_out_line <= '0;
            regRdValid <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            rawQ <= rawD;
            wordQ <= wordD;
            dlyQ <= dlyD;
            minDly_q <= minDly_d;
            maxDly_q <= maxDly_d;
            hold_q <= hold_d;
            late_q <= late_d;
            unsettled_q <= unsettled_d;
            sendWord_q <= sendWord_d;
            sendBit_q <= sendBit_d;
            sendLead_q <= sendLead_d;
            sendDone_q <= sendDone_d;
            frame_strobe_n <= strobeN_d;
            serial_out_line <= lineD;
            regRdValid <= rdValid_d;
        end
    end

endmodule : acf_cal_format

// >>> dv/acf_cal_format_sva.sv
`timescale 1ns/1ps
`include "acf_defs.svh"

module acf_cal_format_sva #(
    parameter logic [23:0] FACTORY_GAIN = `ACF_GAIN_NOMINAL
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register side
    input wire logic regRdEn,
    input wire logic [`ACF_ADDR_W-1:0] regAddr,
    input wire acf_pkg::acf_byte_t regRdData,
    input wire logic regRdValid,
    // Pins
    input wire logic syncIn_n,
    input wire logic bit_clock_out,
    input wire logic frame_strobe_n,
    input wire logic [`ACF_NCH-1:0] serial_out_line
);
    import acf_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_read_answer: assert property (regRdEn |=> regRdValid)
        else $error("read not answered");
    chk_read_cause: assert property (regRdValid |-> $past(regRdEn))
        else $error("read answer without strobe");
    chk_unmapped_zero: assert property (regRdValid && $past(regAddr[2:0]) == 3'h7 |-> regRdData == 8'h00)
        else $error("unmapped field not zero");
    chk_gain_factory: assert property ($rose(rst_n) && regAddr[2:0] == 3'h3 |=> regRdData == FACTORY_GAIN[23:16])
        else $error("gain not factory after reset");
    chk_strobe_width: assert property ($fell(frame_strobe_n) |-> ##15 !frame_strobe_n ##1 frame_strobe_n)
        else $error("strobe width wrong");
    chk_strobe_edge: assert property ($fell(frame_strobe_n) |-> $rose(bit_clock_out))
        else $error("strobe off bit clock rise");
    chk_strobe_lines: assert property (!frame_strobe_n |-> serial_out_line == 8'h00)
        else $error("data during strobe");
    chk_bit_half: assert property ($rose(bit_clock_out) |-> bit_clock_out[*8] ##1 !bit_clock_out)
        else $error("bit clock high time wrong");
    chk_lines_stable: assert property (!$rose(bit_clock_out) |-> $stable(serial_out_line))
        else $error("data moved off bit clock rise");

    cov_frame: cover property ($fell(frame_strobe_n));
    cov_read: cover property (regRdValid && regRdData != 8'h00);
    cov_sync: cover property ($rose(syncIn_n));
endmodule : acf_cal_format_sva

bind acf_cal_format acf_cal_format_sva #(.FACTORY_GAIN(FACTORY_GAIN)) i_acf_cal_format_sva (
    .clk(clk), .rst_n(rst_n), .regRdEn(regRdEn), .regAddr(regAddr), .regRdData(regRdData),
    .regRdValid(regRdValid), .syncIn_n(syncIn_n), .bit_clock_out(bit_clock_out),
    .frame_strobe_n(frame_strobe_n), .serial_out_line(serial_out_line));

// >>> dv/acf_rx_model.sv
`timescale 1ns/1ps

module acf_rx_model (
    // Clock
    input wire logic clk,
    // Link from the converter
    input wire logic bit_clock_out,
    input wire logic frame_strobe_n,
    input wire logic [7:0] serial_out_line,
    // Captured bits
    output logic [191:0] rxBits [8],
    output int rxCount
);
    logic clkPrev_q = 1'b0;
    logic armed_q = 1'b0;

    initial rxCount = 0;

    // Mid-bit sampling on the bit clock fall; no rate of its own
    always @(posedge clk) begin
        clkPrev_q <= bit_clock_out;
        if (clkPrev_q && !bit_clock_out) begin
            if (!frame_strobe_n) begin
                armed_q <= 1'b1;
                rxCount <= 0;
            end else if (armed_q) begin
                for (int i = 0; i < 8; i++) begin
                    rxBits[i] <= {rxBits[i][190:0], serial_out_line[i]};
                end
                rxCount <= rxCount + 1;
            end
        end
    end
endmodule : acf_rx_model

// >>> dv/acf_cal_format_tb.sv
`timescale 1ns/1ps
`include "acf_defs.svh"

module acf_cal_format_tb;
    import acf_pkg::*;
    logic clk;
    logic rst_n;
    logic serialCtrl;
    logic [7:0] chanSinc5;
    logic [2:0] decCode;
    logic regWrEn;
    logic regRdEn;
    logic [5:0] regAddr;
    acf_byte_t regWrData;
    acf_byte_t regRdData;
    logic regRdValid;
    logic rawValid;
    logic [191:0] rawData;
    logic syncIn_n;
    logic layHi;
    logic layLo;
    logic bitClk;
    logic strobe_n;
    logic [7:0] lines;
    logic [191:0] rxBits [8];
    int rxCount;
    int badCount;
    int numChecks;
    logic [23:0] offs [8];
    logic [23:0] gains [8];

    acf_cal_format i_acf_cal_format (.clk(clk), .rst_n(rst_n), .serialCtrl(serialCtrl),
        .chanSinc5(chanSinc5), .decCode(decCode), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .rawValid(rawValid), .rawData(rawData), .syncIn_n(syncIn_n),
        .line_layout_pin_hi(layHi), .line_layout_pin_lo(layLo), .bit_clock_out(bitClk),
        .frame_strobe_n(strobe_n), .serial_out_line(lines));
    acf_rx_model i_acf_rx_model (.clk(clk), .bit_clock_out(bitClk), .frame_strobe_n(strobe_n),
        .serial_out_line(lines), .rxBits(rxBits), .rxCount(rxCount));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Layout pins settle the layout a few cycles after reset is released
    task automatic do_reset(input logic [1:0] pins);
        rst_n = 1'b0;
        regAddr = 6'h03;
        {layHi, layLo} = pins;
        for (int i = 0; i < 8; i++) begin
            offs[i] = 24'h00_0000;
            gains[i] = `ACF_GAIN_NOMINAL;
        end
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (5) @(posedge clk);
        #1;
    endtask : do_reset

    task automatic wr(input logic [5:0] a, input acf_byte_t d);
        @(posedge clk);
        #1 regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(posedge clk);
        #1 regWrEn = 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input acf_byte_t e);
        @(posedge clk);
        #1 regRdEn = 1'b1;
        regAddr = a;
        @(posedge clk);
        #1 regRdEn = 1'b0;
        check({16'h0000, regRdData}, {16'h0000, e});
        check({23'h00_0000, regRdValid}, 24'h00_0001);
    endtask : rd

    function automatic logic [23:0] word_of(input int ch);
        longint p;
        p = (longint'((ch + 1) * 19200) - longint'($signed(offs[ch]))) * longint'(gains[ch]);
        return {3'b000, chanSinc5[ch], 1'b0, ch[2:0], p[45:30]};
    endfunction : word_of

    task automatic t_regs;
        for (int a = 0; a < 64; a++) begin
            rd(a[5:0], (a % 8 >= 3 && a % 8 <= 5) ? 8'h55 : 8'h00);
        end
        serialCtrl = 1'b0;
        wr(6'h08, 8'hA5);
        rd(6'h08, 8'h00);
        serialCtrl = 1'b1;
        wr(6'h01, 8'h12);
        wr(6'h02, 8'hC0);
        wr(6'h0B, 8'h2A);
        wr(6'h0C, 8'hAA);
        wr(6'h0D, 8'hAA);
        wr(6'h0F, 8'hFF);
        rd(6'h01, 8'h12);
        rd(6'h0C, 8'hAA);
        rd(6'h0F, 8'h00);
        offs[0] = 24'h00_12C0;
        gains[1] = 24'h2A_AAAA;
    endtask : t_regs

    // Settling flag is masked here; the sync scenario judges it
    task automatic run_frame(input int cpl);
        int n;
        logic [23:0] e;
        n = 0;
        // Previous frame ends on the rise after its last bit; earlier frames are dropped
        repeat (17) @(posedge clk);
        #1 rawValid = 1'b1;
        @(posedge clk);
        #1 rawValid = 1'b0;
        while (strobe_n !== 1'b0 && n < 500) begin
            @(posedge clk);
            #1 n++;
        end
        while ((strobe_n !== 1'b1 || rxCount != 24 * cpl) && n < 5000) begin
            @(posedge clk);
            #1 n++;
        end
        check({23'h00_0000, n < 5000}, 24'h00_0001);
        for (int l = 0; l < 8; l++) begin
            for (int s = 0; s < cpl; s++) begin
                e = 24'h00_0000;
                if (l * cpl < 8) begin
                    e = word_of(l * cpl + s);
                end
                check(rxBits[l][(cpl - 1 - s) * 24 +: 24] & 24'hBF_FFFF, e);
            end
        end
    endtask : run_frame

    task automatic t_sync;
        chanSinc5 = 8'hFF;
        wr(6'h1E, 8'hFF);
        syncIn_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 syncIn_n = 1'b1;
        repeat (40) @(posedge clk);
        run_frame(8);
        check({23'h00_0000, rxBits[0][190]}, 24'h00_0001);
        run_frame(8);
        check({23'h00_0000, rxBits[0][190]}, 24'h00_0000);
        check({23'h00_0000, rxBits[0][118]}, 24'h00_0001);
    endtask : t_sync

    initial begin
        serialCtrl = 1'b1;
        chanSinc5 = 8'h0F;
        decCode = 3'h0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 8'h00;
        rawValid = 1'b0;
        syncIn_n = 1'b1;
        badCount = 0;
        numChecks = 0;
        for (int c = 0; c < 8; c++) begin
            rawData[24 * c +: 24] = 24'((c + 1) * 19200);
        end
        do_reset(2'b00);
        t_regs;
        run_frame(1);
        do_reset(2'b01);
        t_regs;
        {layHi, layLo} = 2'b11;
        run_frame(4);
        do_reset(2'b10);
        t_sync;
        finish_test;
    end

    // Whole run needs about 10k cycles
    initial begin
        #300_000;
        badCount++;
        finish_test;
    end
endmodule : acf_cal_format_tb
